// ===== bert_pattern_regs.svh
// register offsets, reset value, sync match and half-word bit counts of the pattern word store
// assumes the 8-bit processor port decodes an 8-bit register address
// What this block does
// - four byte registers, low byte lowest address
// - alternating: bits 15:0 first, 31:16 second
// - first alternating word shifts bit 0 first
// - second alternating word shifts bit 16 first
// - repetitive: bit 0 upward, length setting limits
// - each word sent alternating count plus one
// - checker syncs after 32 matching bits
`ifndef BERT_PATTERN_REGS_SVH
`define BERT_PATTERN_REGS_SVH
`define PAT_BYTE0_OFS 8'h3C
`define PAT_BYTE1_OFS 8'h3D
`define PAT_BYTE2_OFS 8'h3E
`define PAT_BYTE3_OFS 8'h3F
`define PAT_BYTE_RST 8'h00
`define SYNC_MATCH_BITS 6'h20
`define HALF_WORD_BITS 5'h10
`endif

// ===== bert_pattern_pkg.sv
// types shared by the pattern word store and its output buffer
// assumes the constants header is included by users needing offsets
package bert_pattern_pkg;
  typedef enum logic [1:0] {
    MODE_PRBS = 2'h0,
    MODE_REPEAT = 2'h1,
    MODE_ALTERNATE = 2'h3
  } pattern_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } host_req_t;
  typedef struct packed {
    logic bit_val;
    logic use_store;
  } tx_bit_t;
endpackage

// ===== bert_skid_buffer.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module bert_skid_buffer
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire bert_pattern_pkg::tx_bit_t in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output bert_pattern_pkg::tx_bit_t out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  bert_pattern_pkg::tx_bit_t mem_reg [2];
  bert_pattern_pkg::tx_bit_t mem_next [2];
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic rd_ptr_reg;
  logic rd_ptr_next;
  logic wr_ptr_reg;
  logic wr_ptr_next;
  logic push;
  logic pop;

  // full and empty are exact, so a stalled sink really stops the source
  assign in_ready_out = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer and occupancy update
  always_comb
  begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push)
    begin
      mem_next[wr_ptr_reg] = in_data_in;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop)
    begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 2'h1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 2'h1;
    end
  end

  // state registers
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

// ===== bert_pattern_word_store.sv
// pattern word store: host byte registers, pattern bit sequencer, receive sync check
// assumes host strobes are one-cycle pulses on mclk_in; rx bits arrive from a pin
`timescale 1ns/1ns
`default_nettype none
`include "bert_pattern_regs.svh"
module bert_pattern_word_store
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire bert_pattern_pkg::host_req_t host_req_in,
  output logic [7:0] host_rdata_out,
  output logic host_rvalid_out,
  input wire bert_pattern_pkg::pattern_mode_t mode_in,
  input wire logic [3:0] pattern_length_setting_in,
  input wire logic [7:0] alternating_repeat_count_in,
  output bert_pattern_pkg::tx_bit_t tx_bit_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic rx_bit_in,
  input wire logic rx_valid_in,
  output logic rx_sync_out,
  output logic [31:0] user_pattern_bits_out
);
  logic [7:0] pattern_byte_0_reg;
  logic [7:0] pattern_byte_1_reg;
  logic [7:0] pattern_byte_2_reg;
  logic [7:0] pattern_byte_3_reg;
  logic [7:0] pattern_byte_0_next;
  logic [7:0] pattern_byte_1_next;
  logic [7:0] pattern_byte_2_next;
  logic [7:0] pattern_byte_3_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] user_pattern_bits;
  logic [4:0] bit_pos_reg;
  logic [4:0] bit_pos_next;
  logic second_word_reg;
  logic second_word_next;
  logic [7:0] rep_cnt_reg;
  logic [7:0] rep_cnt_next;
  logic [4:0] last_bit;
  logic [4:0] tx_index;
  logic use_store;
  bert_pattern_pkg::tx_bit_t gen_bit;
  logic gen_ready;
  logic gen_fire;
  logic [1:0] rx_bit_sync_reg;
  logic [1:0] rx_valid_sync_reg;
  logic [1:0] rx_bit_sync_next;
  logic [1:0] rx_valid_sync_next;
  logic [4:0] rx_pos_reg;
  logic [4:0] rx_pos_next;
  logic rx_second_reg;
  logic rx_second_next;
  logic [7:0] rx_rep_reg;
  logic [7:0] rx_rep_next;
  logic [5:0] match_cnt_reg;
  logic [5:0] match_cnt_next;
  logic sync_reg;
  logic sync_next;
  logic [4:0] rx_index;
  logic expect_bit;

  // byte lanes packed into one word, byte 0 holds the low bits
  assign user_pattern_bits = {pattern_byte_3_reg, pattern_byte_2_reg,
                              pattern_byte_1_reg, pattern_byte_0_reg};
  assign user_pattern_bits_out = user_pattern_bits;
  assign host_rdata_out = rdata_reg;
  assign host_rvalid_out = rvalid_reg;
  assign rx_sync_out = sync_reg;
  // pattern only trusted once host loaded it; not checked here
  assign use_store = (mode_in != bert_pattern_pkg::MODE_PRBS);

  // host byte writes and reads; unmapped reads return zero
  always_comb
  begin
    pattern_byte_0_next = pattern_byte_0_reg;
    pattern_byte_1_next = pattern_byte_1_reg;
    pattern_byte_2_next = pattern_byte_2_reg;
    pattern_byte_3_next = pattern_byte_3_reg;
    rdata_next = rdata_reg;
    rvalid_next = host_req_in.rd;
    if (host_req_in.wr)
    begin
      unique case (host_req_in.addr)
        `PAT_BYTE0_OFS: pattern_byte_0_next = host_req_in.wdata;
        `PAT_BYTE1_OFS: pattern_byte_1_next = host_req_in.wdata;
        `PAT_BYTE2_OFS: pattern_byte_2_next = host_req_in.wdata;
        `PAT_BYTE3_OFS: pattern_byte_3_next = host_req_in.wdata;
        default: ;
      endcase
    end
    if (host_req_in.rd)
    begin
      unique case (host_req_in.addr)
        `PAT_BYTE0_OFS: rdata_next = pattern_byte_0_reg;
        `PAT_BYTE1_OFS: rdata_next = pattern_byte_1_reg;
        `PAT_BYTE2_OFS: rdata_next = pattern_byte_2_reg;
        `PAT_BYTE3_OFS: rdata_next = pattern_byte_3_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pattern_byte_0_reg <= `PAT_BYTE_RST;
      pattern_byte_1_reg <= `PAT_BYTE_RST;
      pattern_byte_2_reg <= `PAT_BYTE_RST;
      pattern_byte_3_reg <= `PAT_BYTE_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      pattern_byte_0_reg <= pattern_byte_0_next;
      pattern_byte_1_reg <= pattern_byte_1_next;
      pattern_byte_2_reg <= pattern_byte_2_next;
      pattern_byte_3_reg <= pattern_byte_3_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // highest bit used: length setting in repeat mode, 15 per alternating half
  assign last_bit = (mode_in == bert_pattern_pkg::MODE_ALTERNATE) ?
                    `HALF_WORD_BITS - 5'h1 : {1'b0, pattern_length_setting_in};
  // second word starts at bit 16, each word lsb first
  assign tx_index = second_word_reg ? (bit_pos_reg + `HALF_WORD_BITS) : bit_pos_reg;
  assign gen_bit.bit_val = use_store ? user_pattern_bits[tx_index] : 1'b0;
  assign gen_bit.use_store = use_store;
  assign gen_fire = gen_ready && use_store;

  // transmit sequencer: walk bits, then repeat or swap words
  always_comb
  begin
    bit_pos_next = bit_pos_reg;
    second_word_next = second_word_reg;
    rep_cnt_next = rep_cnt_reg;
    if (!use_store)
    begin
      bit_pos_next = 5'h00;
      second_word_next = 1'b0;
      rep_cnt_next = 8'h00;
    end
    else if (gen_fire)
    begin
      if (bit_pos_reg >= last_bit)
      begin
        bit_pos_next = 5'h00;
        if (mode_in == bert_pattern_pkg::MODE_ALTERNATE)
        begin
          if (rep_cnt_reg >= alternating_repeat_count_in)
          begin
            rep_cnt_next = 8'h00;
            second_word_next = ~second_word_reg;
          end
          else
          begin
            rep_cnt_next = rep_cnt_reg + 8'h01;
          end
        end
      end
      else
      begin
        bit_pos_next = bit_pos_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bit_pos_reg <= 5'h00;
      second_word_reg <= 1'b0;
      rep_cnt_reg <= 8'h00;
    end
    else
    begin
      bit_pos_reg <= bit_pos_next;
      second_word_reg <= second_word_next;
      rep_cnt_reg <= rep_cnt_next;
    end
  end

  // buffer absorbs a receiver stall without losing a bit
  bert_skid_buffer u_tx_buffer
  (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .in_data_in(gen_bit),
    .in_valid_in(use_store),
    .in_ready_out(gen_ready),
    .out_data_out(tx_bit_out),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in)
  );

  // receive side: rx pins synchronised through two flops first
  assign rx_index = rx_second_reg ? (rx_pos_reg + `HALF_WORD_BITS) : rx_pos_reg;
  assign expect_bit = user_pattern_bits[rx_index];

  // expected-bit walk mirrors the generator; 32 matches declare sync
  always_comb
  begin
    rx_bit_sync_next = {rx_bit_sync_reg[0], rx_bit_in};
    rx_valid_sync_next = {rx_valid_sync_reg[0], rx_valid_in};
    rx_pos_next = rx_pos_reg;
    rx_second_next = rx_second_reg;
    rx_rep_next = rx_rep_reg;
    match_cnt_next = match_cnt_reg;
    sync_next = sync_reg;
    if (!use_store)
    begin
      rx_pos_next = 5'h00;
      rx_second_next = 1'b0;
      rx_rep_next = 8'h00;
      match_cnt_next = 6'h00;
      sync_next = 1'b0;
    end
    else if (rx_valid_sync_reg[1])
    begin
      if (rx_pos_reg >= last_bit)
      begin
        rx_pos_next = 5'h00;
        if (mode_in == bert_pattern_pkg::MODE_ALTERNATE)
        begin
          if (rx_rep_reg >= alternating_repeat_count_in)
          begin
            rx_rep_next = 8'h00;
            rx_second_next = ~rx_second_reg;
          end
          else
          begin
            rx_rep_next = rx_rep_reg + 8'h01;
          end
        end
      end
      else
      begin
        rx_pos_next = rx_pos_reg + 5'h01;
      end
      // a miss restarts the count; in hunt the walk slides by one bit
      if (rx_bit_sync_reg[1] == expect_bit)
      begin
        if (match_cnt_reg < `SYNC_MATCH_BITS)
        begin
          match_cnt_next = match_cnt_reg + 6'h01;
        end
        if (match_cnt_reg == `SYNC_MATCH_BITS - 6'h01)
        begin
          sync_next = 1'b1;
        end
      end
      else
      begin
        match_cnt_next = 6'h00;
        if (!sync_reg)
        begin
          rx_pos_next = rx_pos_reg;
          rx_second_next = rx_second_reg;
          rx_rep_next = rx_rep_reg;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rx_bit_sync_reg <= 2'h0;
      rx_valid_sync_reg <= 2'h0;
      rx_pos_reg <= 5'h00;
      rx_second_reg <= 1'b0;
      rx_rep_reg <= 8'h00;
      match_cnt_reg <= 6'h00;
      sync_reg <= 1'b0;
    end
    else
    begin
      rx_bit_sync_reg <= rx_bit_sync_next;
      rx_valid_sync_reg <= rx_valid_sync_next;
      rx_pos_reg <= rx_pos_next;
      rx_second_reg <= rx_second_next;
      rx_rep_reg <= rx_rep_next;
      match_cnt_reg <= match_cnt_next;
      sync_reg <= sync_next;
    end
  end
endmodule
`default_nettype wire

// ===== bert_pattern_word_store_checker.sv
// port-level checker for the pattern word store
// assumes it is bound onto bert_pattern_word_store
`timescale 1ns/1ns
`default_nettype none
`include "bert_pattern_regs.svh"
module bert_pattern_word_store_checker
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire bert_pattern_pkg::host_req_t host_req_in,
  input wire logic [7:0] host_rdata_out,
  input wire logic host_rvalid_out,
  input wire bert_pattern_pkg::pattern_mode_t mode_in,
  input wire bert_pattern_pkg::tx_bit_t tx_bit_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic rx_sync_out,
  input wire logic [31:0] user_pattern_bits_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic [5:0] run_cnt_reg;
  logic [5:0] run_cnt_next;
  // cycles spent in a store mode, saturating so it never wraps
  always_comb
  begin
    run_cnt_next = run_cnt_reg;
    if (mode_in == bert_pattern_pkg::MODE_PRBS)
      run_cnt_next = 6'h00;
    else if (run_cnt_reg != 6'h3F)
      run_cnt_next = run_cnt_reg + 6'h01;
  end
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      run_cnt_reg <= 6'h00;
    else
      run_cnt_reg <= run_cnt_next;
  end
  // byte placement and read path
  a_low_byte: assert property (
    host_req_in.wr && host_req_in.addr == `PAT_BYTE0_OFS
    |=> user_pattern_bits_out[7:0] == $past(host_req_in.wdata))
    else $error("low pattern byte not written");
  a_high_byte: assert property (
    host_req_in.wr && host_req_in.addr == `PAT_BYTE3_OFS
    |=> user_pattern_bits_out[31:24] == $past(host_req_in.wdata))
    else $error("high pattern byte not written");
  a_read_echo: assert property (
    host_req_in.rd && host_req_in.addr == `PAT_BYTE2_OFS
    |=> host_rvalid_out && host_rdata_out == $past(user_pattern_bits_out[23:16]))
    else $error("byte two read wrong");
  a_rvalid_cause: assert property (
    host_rvalid_out |-> $past(host_req_in.rd))
    else $error("read valid without read");
  // stream side
  a_bit_held: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_bit_out))
    else $error("stalled bit changed");
  a_store_flag: assert property (
    tx_valid_out |-> tx_bit_out.use_store)
    else $error("bit not from store");
  a_prbs_nosync: assert property (
    (mode_in == bert_pattern_pkg::MODE_PRBS) [*2] |-> !rx_sync_out)
    else $error("sync held in pseudorandom mode");
  // an empty buffer must stay empty while the store is not in use
  a_prbs_no_bits: assert property (
    mode_in == bert_pattern_pkg::MODE_PRBS && !tx_valid_out |=> !tx_valid_out)
    else $error("bit produced in pseudorandom mode");
  a_sync_after_run: assert property (
    $rose(rx_sync_out) |-> run_cnt_reg >= `SYNC_MATCH_BITS)
    else $error("sync too early");
endmodule
`default_nettype wire

// ===== bert_bit_partner.sv
// far side: random-stall bit sink that loops accepted bits back to rx
// assumes the bench seeds $urandom; one clock, active-low async reset
`timescale 1ns/1ns
`default_nettype none
module bert_bit_partner
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire bert_pattern_pkg::tx_bit_t tx_bit_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic rx_bit_out,
  output logic rx_valid_out
);
  // idle rx line shows the inverse so stale bits never match by luck
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tx_ready_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_bit_out <= 1'b0;
    end
    else
    begin
      tx_ready_out <= ($urandom % 4) != 0; // stalls about one cycle in four
      rx_valid_out <= tx_valid_in && tx_ready_out;
      rx_bit_out <= (tx_valid_in && tx_ready_out) ? tx_bit_in.bit_val : ~rx_bit_out;
    end
  end
endmodule
`default_nettype wire

// ===== tb_bert_pattern_word_store.sv
// self-checking bench for the pattern word store
// assumes the checker and partner files are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_bert_pattern_word_store;
  logic mclk_in, nrst_in, rvalid, tx_valid, tx_ready, rx_bit, rx_valid, rx_sync;
  bert_pattern_pkg::host_req_t host_req;
  bert_pattern_pkg::pattern_mode_t mode;
  bert_pattern_pkg::tx_bit_t tx_bit;
  logic [3:0] len;
  logic [7:0] alternating_repeat_count, rdata;
  logic [31:0] pat, pat_out;
  logic seen[$];
  int n_fail, compares, k;
  bert_pattern_word_store u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .host_req_in(host_req), .host_rdata_out(rdata), .host_rvalid_out(rvalid),
    .mode_in(mode), .pattern_length_setting_in(len), .alternating_repeat_count_in(alternating_repeat_count),
    .tx_bit_out(tx_bit), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .rx_bit_in(rx_bit), .rx_valid_in(rx_valid), .rx_sync_out(rx_sync),
    .user_pattern_bits_out(pat_out));
  bert_bit_partner u_far (.mclk_in(mclk_in), .nrst_in(nrst_in), .tx_bit_in(tx_bit),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_bit_out(rx_bit),
    .rx_valid_out(rx_valid));
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // record every bit the far side accepts
  always @(posedge mclk_in)
  begin
    if (nrst_in && tx_valid && tx_ready)
      seen.push_back(tx_bit.bit_val);
  end
  task automatic print_verdict();
  begin
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
  begin
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // host strobes are one cycle; the caller drops wr after the last write
  task automatic host_wr(logic [7:0] a, logic [7:0] d);
  begin
    host_req <= {a, d, 2'b10};
    @(posedge mclk_in);
  end
  endtask
  task automatic host_rd(logic [7:0] a, logic [7:0] exp);
  begin
    host_req <= {a, 8'h00, 2'b01};
    @(posedge mclk_in);
    host_req <= '0;
    #1;
    chk_val("rvalid", 32'h1, {31'h0, rvalid});
    chk_val("rdata", {24'h0, exp}, {24'h0, rdata});
    @(posedge mclk_in);
  end
  endtask
  task automatic load_pat(logic [31:0] p);
    int j;
  begin
    for (j = 0; j < 4; j++)
      host_wr(8'h3C + 8'(j), p[8 * j +: 8]);
    host_req <= '0;
    @(posedge mclk_in);
    pat = p;
  end
  endtask
  task automatic wait_bits(int n);
    int j;
  begin
    for (j = 0; j < 5000 && seen.size() < n; j++)
      @(posedge mclk_in);
    if (seen.size() < n)
    begin
      n_fail++;
      $display("BAD bit count expected %0d seen %0d", n, seen.size());
      print_verdict();
    end
  end
  endtask
  function automatic logic exp_bit(logic [31:0] p, logic alt, int l, int a, int i);
    int j;
    j = i % (32 * (a + 1));
    if (alt)
      return p[(j >= 16 * (a + 1) ? 16 : 0) + j % 16];
    return p[i % (l + 1)];
  endfunction
  // park in pseudorandom mode, then run one store mode through the loopback
  task automatic run_mode(bert_pattern_pkg::pattern_mode_t m, logic [3:0] l, logic [7:0] a);
    int j;
    int n;
  begin
    n = 32 * (a + 1) + 64;
    mode <= bert_pattern_pkg::MODE_PRBS;
    repeat (30) @(posedge mclk_in);
    seen.delete();
    repeat (20) @(posedge mclk_in);
    chk_val("prbs bits", 32'h0, seen.size());
    chk_val("prbs sync", 32'h0, {31'h0, rx_sync});
    len <= l;
    alternating_repeat_count <= a;
    mode <= m;
    wait_bits(20);
    chk_val("early sync", 32'h0, {31'h0, rx_sync});
    wait_bits(n);
    repeat (4) @(posedge mclk_in);
    chk_val("sync", 32'h1, {31'h0, rx_sync});
    for (j = 0; j < n; j++)
      chk_val("tx bit", {31'h0, exp_bit(pat, m == bert_pattern_pkg::MODE_ALTERNATE, l, a, j)},
        {31'h0, seen[j]});
    $display("test mode %0d len %0d count %0d done", m, l, a);
  end
  endtask
  initial
  begin
    n_fail = 0;
    compares = 0;
    nrst_in = 1'b0;
    host_req = '0;
    mode = bert_pattern_pkg::MODE_PRBS;
    len = 4'h0;
    alternating_repeat_count = 8'h00;
    void'($urandom(32'h3E2A6D65));
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    for (k = 0; k < 5; k++)
      host_rd(8'h3C + 8'(k), 8'h00);
    $display("test reset values done");
    load_pat($urandom);
    chk_val("pattern", pat, pat_out);
    for (k = 0; k < 4; k++)
      host_rd(8'h3C + 8'(k), pat[8 * k +: 8]);
    $display("test byte placement done");
    run_mode(bert_pattern_pkg::MODE_REPEAT, 4'h0, 8'h00);
    run_mode(bert_pattern_pkg::MODE_REPEAT, 4'hF, 8'h00);
    run_mode(bert_pattern_pkg::MODE_REPEAT, 4'($urandom), 8'h00);
    load_pat(32'h7E7E0000);
    run_mode(bert_pattern_pkg::MODE_ALTERNATE, 4'h0, 8'h00);
    load_pat($urandom);
    run_mode(bert_pattern_pkg::MODE_ALTERNATE, 4'h0, 8'($urandom % 3));
    print_verdict();
  end
endmodule
bind bert_pattern_word_store bert_pattern_word_store_checker u_chk
(
  .mclk_in(mclk_in),
  .nrst_in(nrst_in),
  .host_req_in(host_req_in),
  .host_rdata_out(host_rdata_out),
  .host_rvalid_out(host_rvalid_out),
  .mode_in(mode_in),
  .tx_bit_out(tx_bit_out),
  .tx_valid_out(tx_valid_out),
  .tx_ready_in(tx_ready_in),
  .rx_sync_out(rx_sync_out),
  .user_pattern_bits_out(user_pattern_bits_out)
);
`default_nettype wire
